/* File: logic/awt_pkg.sv */
// Purpose: Shared constants and types for the halt auto-wakeup timer
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes:   Offsets 0x48/0x49 are word indices, not byte offsets: byte address = 4*idx
package awt_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] CSR_IDX   = 8'h48;  // Control/status index
  localparam logic [7:0] PRE_IDX   = 8'h49;  // Prescale index
  localparam logic [9:0] CSR_ADDR  = {CSR_IDX, 2'b00};
  localparam logic [9:0] PRE_ADDR  = {PRE_IDX, 2'b00};
  localparam logic [9:0] HALT_ADDR = 10'h200; // Halt status word index, writes ignored

  // ==========================================================
  // Fields and reset values
  // ==========================================================
  localparam int         FLAG_BIT  = 2;
  localparam int         MEAS_BIT  = 1;
  localparam int         EN_BIT    = 0;
  localparam logic [7:0] CSR_RST   = 8'h00;
  localparam logic [7:0] PRE_RST   = 8'hFF;
  localparam logic [7:0] PRE_BAD   = 8'h00;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ        = 125;
  localparam int FIXED_DIV      = 64;   // Fixed divider ahead of prescaler
  localparam int STAB_CYCLES    = 256;  // Main oscillator stabilisation
  localparam int OSC_DIV        = 32;   // Model wake RC as sysclk/OSC_DIV
  localparam int STARTUP_OSC    = 4;    // Wake RC start-up, in RC periods

  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  // Power state machine
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_HALT  = 4'b0010,
    ST_WAKE  = 4'b0100,
    ST_STAB  = 4'b1000
  } awt_state_t;

  // Halt control bundle to the core
  typedef struct packed {
    logic mainOscOn;
    logic intMaskClr;
    logic pushCc;
    logic wakeIrq;
  } awt_core_t;

endpackage : awt_pkg

/* File: logic/awt_timer.sv */
// Purpose: Auto-wakeup from halt timer with AXI4-Lite registers
// Assumes: Wake RC oscillator modelled as enable pulse from sysclk divider
// Notes:   Core sequencing signals are flip-flop outputs
//
// Operation
// - HALT with wake_enable enters auto-wake halt
// - Wake RC feeds fixed then programmable divider
// - Expiry sets wake_flag and raises interrupt
// - Restart main oscillator, wait 256 cycles
// - Reading control register clears flag, interrupt
// - Writes to wake_flag position ignored
// - osc_measure routes RC clock to capture
// - Reset or exit interrupt also leaves halt
// - Entry forces interrupt mask bit zero
// - Main oscillator stopped during halt
// - Watchdog reset on HALT follows option
// - Push condition_code before servicing interrupt; pushCc only if wake_flag set
// - Control resets zero, upper bits zero
// - Flag bit2, measure bit1, enable bit0
// - Prescale register resets to all ones
// - Dividing factor equals prescale value
// - Zero write to prescale ignored
// - Halt time 64 times prescale plus start-up
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module awt_timer #(
  parameter int STAB = awt_pkg::STAB_CYCLES  // Stabilisation cycles
) (
  // Clock and reset
  input  wire  logic        clock,
  input  wire  logic        sys_rst,
  // Core halt handshake
  input  wire  logic        haltExec,     // HALT instruction executed
  input  wire  logic        exitIrq,      // Other exit-capable interrupt
  input  wire  logic        watchdogOn,   // Watchdog system enabled
  input  wire  logic        watchdogHaltOpt, // watchdog_halt_option
  output var   awt_pkg::awt_core_t core,  // Core sequencing
  output logic              inHalt,       // Auto-wake halt active
  output logic              wdgReset,     // Watchdog reset request
  output logic              captureClk,   // Wake RC to Lite timer capture
  // AXI4-Lite write
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready
);

  // ==========================================================
  // Declarations
  // ==========================================================
  awt_pkg::awt_state_t state_r;            // Power state
  logic        enable_r;                   // wake_enable
  logic        measure_r;                  // osc_measure
  logic        flag_r;                     // wake_flag
  logic [7:0]  prescale_r;                 // wake_prescale
  logic [4:0]  oscDiv_r;                   // RC model divider
  logic        oscTick;                    // One wake RC period
  logic [5:0]  fixCnt_r;                   // Fixed divide-by-64
  logic [7:0]  preCnt_r;                   // Programmable count
  logic [2:0]  startCnt_r;                 // RC start-up periods
  logic [8:0]  stabCnt_r;                  // Stabilisation count
  logic        expire;                     // Delay elapsed
  logic [9:0]  awIdx_r;                    // Latched write word addr
  logic [31:0] wData_r;                    // Latched write data
  logic [3:0]  wStrb_r;                    // Latched strobes
  logic        haveAw_r;                   // Address held
  logic        haveW_r;                    // Data held
  logic        doWrite;                    // Commit write this cycle
  logic        rdCsr;                      // Control read commits
  logic [9:0]  stabLen_r;                  // Stabilisation length check

  // Word-index decode, used by read and write paths
  function automatic logic [1:0] decode(input logic [11:0] a);
    if (a[11:2] == {2'b00, awt_pkg::CSR_IDX})       decode = 2'd1;
    else if (a[11:2] == {2'b00, awt_pkg::PRE_IDX})  decode = 2'd2;
    else if (a[11:2] == awt_pkg::HALT_ADDR) decode = 2'd3;
    else                                    decode = 2'd0;
  endfunction : decode

  // ==========================================================
  // AXI write channel
  // ==========================================================
  assign doWrite = haveAw_r && haveW_r && !s_axi_bvalid;

  // Address and data taken independently, response after both
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      haveAw_r      <= 1'b0;
      haveW_r       <= 1'b0;
      awIdx_r       <= 10'h000;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= awt_pkg::RESP_OK;
    end else begin
      s_axi_awready <= !haveAw_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !haveW_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw_r <= 1'b1;
        awIdx_r  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        // Unmapped word answers SLVERR
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (decode({awIdx_r, 2'b00}) == 2'd0) ?
                        awt_pkg::RESP_ERR : awt_pkg::RESP_OK;
        haveAw_r     <= 1'b0;
        haveW_r      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI read channel
  // ==========================================================
  assign rdCsr = s_axi_arvalid && s_axi_arready &&
                 decode(s_axi_araddr) == 2'd1;

  // One-cycle accept pulse, data the cycle after
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= awt_pkg::RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= awt_pkg::RESP_OK;
        s_axi_rdata  <= 32'h0000_0000;
        unique case (decode(s_axi_araddr))
          2'd1: s_axi_rdata[2:0] <= {flag_r, measure_r, enable_r};
          2'd2: s_axi_rdata[7:0] <= prescale_r;
          2'd3: s_axi_rdata[1:0] <= {wdgReset, inHalt};
          2'd0: s_axi_rresp <= awt_pkg::RESP_ERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Control bits and prescaler, low byte lane only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enable_r   <= awt_pkg::CSR_RST[awt_pkg::EN_BIT];
      measure_r  <= awt_pkg::CSR_RST[awt_pkg::MEAS_BIT];
      prescale_r <= awt_pkg::PRE_RST;
    end else if (doWrite && wStrb_r[0]) begin
      if (decode({awIdx_r, 2'b00}) == 2'd1) begin
        // Enable and measure bits; flag not written
        enable_r  <= wData_r[awt_pkg::EN_BIT];
        measure_r <= wData_r[awt_pkg::MEAS_BIT];
      end
      if (decode({awIdx_r, 2'b00}) == 2'd2 &&
          wData_r[7:0] != awt_pkg::PRE_BAD)
        prescale_r <= wData_r[7:0];
    end
  end

  // Flag: set wins over clear-on-read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flag_r <= awt_pkg::CSR_RST[awt_pkg::FLAG_BIT];
    end else if (expire) begin
      flag_r <= 1'b1;
    end else if (rdCsr) begin
      flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Wake RC oscillator model and dividers
  // ==========================================================
  // RC runs only in halt or measurement, saving power otherwise
  always_ff @(posedge clock) begin
    if (sys_rst || !(state_r == awt_pkg::ST_HALT || measure_r))
      oscDiv_r <= 5'h00;
    else
      oscDiv_r <= oscDiv_r + 5'h01;
  end
  assign oscTick = (oscDiv_r == 5'(awt_pkg::OSC_DIV - 1));

  always_ff @(posedge clock) begin
    if (sys_rst) captureClk <= 1'b0;
    else captureClk <= measure_r && oscDiv_r[4];
  end

  // Fixed /64 then prescaler; cleared outside halt
  always_ff @(posedge clock) begin
    if (sys_rst || state_r != awt_pkg::ST_HALT || !enable_r) begin
      startCnt_r <= 3'h0;
      fixCnt_r   <= 6'h00;
      preCnt_r   <= 8'h00;
    end else if (oscTick) begin
      if (startCnt_r != 3'(awt_pkg::STARTUP_OSC))
        startCnt_r <= startCnt_r + 3'h1;
      else begin
        fixCnt_r <= fixCnt_r + 6'h01;
        if (fixCnt_r == 6'(awt_pkg::FIXED_DIV - 1))
          preCnt_r <= preCnt_r + 8'h01;
      end
    end
  end

  assign expire = state_r == awt_pkg::ST_HALT && enable_r && oscTick &&
                  startCnt_r == 3'(awt_pkg::STARTUP_OSC) &&
                  fixCnt_r == 6'(awt_pkg::FIXED_DIV - 1) &&
                  preCnt_r == prescale_r - 8'h01;

  // ==========================================================
  // Power state machine
  // ==========================================================
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r   <= awt_pkg::ST_RUN;
      stabCnt_r <= 9'h000;
    end else begin
      unique case (state_r)
        awt_pkg::ST_RUN: begin
          if (haltExec && enable_r) state_r <= awt_pkg::ST_HALT;
        end
        awt_pkg::ST_HALT: begin
          if (expire || exitIrq) state_r <= awt_pkg::ST_WAKE;
        end
        awt_pkg::ST_WAKE: begin
          stabCnt_r <= 9'h000;
          state_r   <= awt_pkg::ST_STAB;
        end
        awt_pkg::ST_STAB: begin
          stabCnt_r <= stabCnt_r + 9'h001;
          if (stabCnt_r == 9'(STAB - 1)) state_r <= awt_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Core handshake outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core     <= '{mainOscOn: 1'b1, intMaskClr: 1'b0,
                    pushCc: 1'b0, wakeIrq: 1'b0};
      inHalt   <= 1'b0;
      wdgReset <= 1'b0;
    end else begin
      core.mainOscOn  <= !(state_r == awt_pkg::ST_HALT);
      core.intMaskClr <= state_r == awt_pkg::ST_RUN && haltExec &&
                         enable_r;
      core.pushCc     <= state_r == awt_pkg::ST_STAB &&
                         stabCnt_r == 9'(STAB - 1) && flag_r;
      // Interrupt follows flag; read clears it
      core.wakeIrq    <= (flag_r || expire) && !(rdCsr && !expire);
      inHalt          <= state_r == awt_pkg::ST_HALT;
      // Watchdog reset unless option allows halt
      wdgReset        <= haltExec && watchdogOn && !watchdogHaltOpt &&
                         state_r == awt_pkg::ST_RUN;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_zero_write_ignored: assert property (
    @(posedge clock) disable iff (sys_rst)
    doWrite && wStrb_r[0] && decode({awIdx_r, 2'b00}) == 2'd2 &&
    wData_r[7:0] == 8'h00 |=> $stable(prescale_r))
    else $error("zero prescale write changed register");

  a_flag_set_expiry: assert property (
    @(posedge clock) disable iff (sys_rst)
    expire |=> flag_r && state_r == awt_pkg::ST_WAKE)
    else $error("expiry did not set flag or wake");

  a_read_clears_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    rdCsr && !expire |=> !flag_r && !core.wakeIrq)
    else $error("read did not clear flag");

  // Helper: cycles spent in stabilisation, long waits need a counter
  always_ff @(posedge clock) begin
    if (sys_rst || state_r != awt_pkg::ST_STAB) stabLen_r <= 10'h000;
    else stabLen_r <= stabLen_r + 10'h001;
  end
  a_stab_length: assert property (
    @(posedge clock) disable iff (sys_rst)
    (state_r == awt_pkg::ST_WAKE || state_r == awt_pkg::ST_STAB) |=>
    state_r == ((stabLen_r == 10'(STAB)) ? awt_pkg::ST_RUN : awt_pkg::ST_STAB))
    else $error("stabilisation length wrong");

  a_halt_entry: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_r == awt_pkg::ST_RUN && haltExec |=>
    (state_r == awt_pkg::ST_HALT) == $past(enable_r))
    else $error("halt entry mismatch");

  a_mask_cleared: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(inHalt) |-> $past(core.intMaskClr))
    else $error("mask not cleared on entry");

  a_osc_stopped: assert property (
    @(posedge clock) disable iff (sys_rst)
    inHalt |-> !core.mainOscOn)
    else $error("main oscillator running in halt");

  a_counter_idle: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_r != awt_pkg::ST_HALT |=> preCnt_r == 8'h00 && fixCnt_r == 6'h00)
    else $error("wake counter not idle");

  a_exit_interrupt: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_r == awt_pkg::ST_HALT && exitIrq |=> state_r == awt_pkg::ST_WAKE)
    else $error("exit interrupt ignored");

  a_wdg_option: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_r == awt_pkg::ST_RUN && haltExec && watchdogOn && watchdogHaltOpt
    |=> !wdgReset)
    else $error("watchdog reset despite option");

endmodule : awt_timer
`default_nettype wire

/* File: tb/awt_timer_tb.sv */
// Purpose: Self-checking bench for the halt auto-wakeup timer
// Assumes: STAB left at 256; all ports driven on rising edges
// Notes:   Bench stands in for core and software, no far-side model
`timescale 1ns/1ps
`default_nettype none
module awt_timer_tb;
  // ==========================================================
  // Signals
  // ==========================================================
  logic               clock = 1'b0;    // 125 MHz system clock
  logic               sys_rst = 1'b1;  // Synchronous reset
  logic               haltExec = 1'b0, exitIrq = 1'b0;
  logic               watchdogOn = 1'b0, watchdogHaltOpt = 1'b0;
  awt_pkg::awt_core_t core;            // Core sequencing bundle
  logic               inHalt, wdgReset, captureClk;
  logic [11:0]        awaddr = '0, araddr = '0;
  logic [31:0]        wdata = '0, rdata;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  int                 errors = 0, comparisons = 0;
  logic               sawMask, sawOscOff, sawWdg;  // Seen while waiting
  logic [31:0]        rd;                          // Read result
  logic [1:0]         rs;                          // Response code
  logic               capPrev;                     // Previous capture level
  int                 n;
  // Register byte addresses, index times four
  localparam logic [11:0] CSR = {2'b00, awt_pkg::CSR_ADDR};
  localparam logic [11:0] PRE = {2'b00, awt_pkg::PRE_ADDR};

  always #4 clock = ~clock;

  awt_timer #(.STAB(256)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .haltExec(haltExec),
    .exitIrq(exitIrq), .watchdogOn(watchdogOn),
    .watchdogHaltOpt(watchdogHaltOpt), .core(core), .inHalt(inHalt),
    .wdgReset(wdgReset), .captureClk(captureClk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ==========================================================
  // Verdict and comparisons
  // ==========================================================
  task automatic end_sim;
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Range check for cycle and edge counts measured by the bench
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      errors++;
      $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Bounded wait failure ends the run
  task automatic hang(input string nm);
    errors++;
    $display("unexpected %s exp answer got timeout", nm);
    end_sim();
  endtask : hang

  // ==========================================================
  // AXI4-Lite master
  // ==========================================================
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int k;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 100) hang("bvalid");
    r = bresp;
    bready <= 1'b0;
    // Let an edge pass so a following call never reassigns bready now
    @(posedge clock);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int k;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 100) hang("rvalid");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Let an edge pass so a following call never reassigns rready now
    @(posedge clock);
  endtask : axi_rd

  // Read a register and compare data and response
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e, input logic [1:0] er);
    axi_rd(a, rd, rs);
    chk(nm, e, rd);
    chk({nm, "_resp"}, {30'h0, er}, {30'h0, rs});
  endtask : rd_chk

  // ==========================================================
  // Core side helpers
  // ==========================================================
  // CPU clock taken as already slowed
  task automatic pulse_halt;
    @(posedge clock) haltExec <= 1'b1;
    @(posedge clock) haltExec <= 1'b0;
  endtask : pulse_halt

  // Wait for a core bit (0..3) or halt exit (4), counting cycles
  task automatic wait_sig(input int sel, input int lim, output int c);
    logic hit;
    for (c = 0; c < lim; c++) begin
      // Values seen at the edge, so one-cycle pulses are not missed
      @(posedge clock);
      if (core.intMaskClr === 1'b1) sawMask = 1'b1;
      if (core.mainOscOn === 1'b0) sawOscOff = 1'b1;
      if (wdgReset === 1'b1) sawWdg = 1'b1;
      hit = (sel == 4) ? (inHalt === 1'b0) : (core[sel] === 1'b1);
      if (hit) break;
    end
  endtask : wait_sig

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd_chk("csr_rst", CSR, 32'h0, awt_pkg::RESP_OK);
    rd_chk("pre_rst", PRE, 32'hFF, awt_pkg::RESP_OK);
    axi_wr(PRE, 32'h0, rs);
    rd_chk("pre_zero", PRE, 32'hFF, awt_pkg::RESP_OK);
    axi_wr(CSR, 32'hFF, rs);
    rd_chk("csr_wr", CSR, 32'h3, awt_pkg::RESP_OK);
    axi_wr(12'h7FC, 32'h1, rs);
    chk("bad_bresp", awt_pkg::RESP_ERR, rs);
    rd_chk("bad_rd", 12'h7FC, 32'h0, awt_pkg::RESP_ERR);
    // Measurement routes the RC model clock out, then stops it
    n = 0;
    capPrev = captureClk;
    repeat (256) begin
      @(posedge clock);
      if (captureClk === 1'b1 && capPrev !== 1'b1) n++;
      capPrev = captureClk;
    end
    chk_rng("capture_rises", 7, 9, n);
    axi_wr(CSR, 32'h0, rs);
    repeat (4) @(posedge clock);
    n = 0;
    capPrev = captureClk;
    repeat (128) begin
      @(posedge clock);
      if (captureClk !== capPrev) n++;
      capPrev = captureClk;
    end
    chk_rng("capture_idle", 0, 0, n);
    // HALT with enable clear: no auto-wake halt; watchdog option
    watchdogOn <= 1'b1;
    for (int o = 0; o < 2; o++) begin
      watchdogHaltOpt <= o[0];
      sawWdg = 1'b0;
      pulse_halt();
      repeat (4) @(posedge clock) if (wdgReset === 1'b1) sawWdg = 1'b1;
      chk("wdg_reset", {31'h0, ~o[0]}, {31'h0, sawWdg});
      chk("no_halt", 32'h0, {31'h0, inHalt});
    end
    watchdogOn <= 1'b0;
    // Timed wakeups for two prescale values, the second run twice
    for (int p = 1; p <= 3; p++) begin
      axi_wr(PRE, (p == 1) ? 32'h1 : 32'h2, rs);
      axi_wr(CSR, 32'h1, rs);
      sawMask = 1'b0; sawOscOff = 1'b0;
      pulse_halt();
      wait_sig(0, 20000, n);
      chk("in_halt_seen", 32'h1, {31'h0, sawOscOff});
      chk("mask_clr", 32'h1, {31'h0, sawMask});
      chk_rng("halt_len",
        (awt_pkg::STARTUP_OSC + 64 * ((p == 1) ? 1 : 2)) * 32 - 32,
        (awt_pkg::STARTUP_OSC + 64 * ((p == 1) ? 1 : 2)) * 32 + 40,
        n);
      wait_sig(1, 400, n);
      chk_rng("stab_len", 256, 262, n);
      chk("osc_on", 32'h1, {31'h0, core.mainOscOn});
      rd_chk("flag_set", CSR, 32'h5, awt_pkg::RESP_OK);
      repeat (2) @(posedge clock);
      chk("irq_clr", 32'h0, {31'h0, core.wakeIrq});
      rd_chk("flag_clr", CSR, 32'h1, awt_pkg::RESP_OK);
    end
    // Another exit interrupt ends the halt early without the flag
    axi_wr(PRE, 32'hFF, rs);
    pulse_halt();
    repeat (100) @(posedge clock);
    rd_chk("halt_word", 12'h800, 32'h1, awt_pkg::RESP_OK);
    exitIrq <= 1'b1;
    wait_sig(4, 400, n);
    chk_rng("exit_len", 0, 300, n);
    exitIrq <= 1'b0;
    repeat (300) @(posedge clock);
    rd_chk("exit_flag", CSR, 32'h1, awt_pkg::RESP_OK);
    end_sim();
  end
endmodule : awt_timer_tb
`default_nettype wire
